// [src/tlbmr_top.sv]
// Miss reload support: miss capture, compare words, group addresses, save word, TLB write.
// Assumes the core stalls issue until older work retires and supplies decoded SPR strobes.
// How it works
// [R1] Group addresses differ only in bits 7-25
// [R2] Top seven bits from table origin field
// [R3] Low six group bits forced zero
// [R4] Group addresses read-only, hardware derived
// [R5] Software loads reload word before TLB load
// [R6] TLB load merges address, compare, reload
// [R7] Entry chosen by operand address and way
// [R8] Reload word keeps documented field layout
// [R9] Miss captures effective address per side
// [R10] Older work completes, save word captured
// [R11] Miss builds compare word for table search
// [R12] Handler compares primary entries, loads reload
// [R13] Handler walks eight primary, then secondary
// [R14] Handler synthesizes page fault if unfound
// [R15] Handler sets changed bit on stores
// [R16] Instruction side versus data side registers
// [R17] Handler reports protection faults distinctly
// [R18] Instruction miss vectors to offset 1000
// [R19] Save word holds field zero, way, state
// [R20] Shadow scratch registers on miss entry
// [R21] Way bit at 14, software overridable
// [R22] Compare valid set, hash identifier cleared
// [R23] Supervisor-only access to these registers
// [R24] Reserved bits read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
module tlbmr_top
   import tlbmr_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Miss event from translation units
   input  wire logic        imiss_i,
   input  wire logic        dmiss_i,
   input  wire logic        dstore_i,
   input  wire logic        older_done_i,
   input  wire logic [31:0] miss_ea_i,
   input  wire logic [23:0] miss_vsid_i,
   input  wire logic        miss_key_i,
   input  wire logic        lru_way_i,
   input  wire logic [3:0]  cond_field_zero_i,
   input  wire logic [15:0] msr_low_i,
   input  wire logic [31:0] table_base_reg_i,
   // SPR access and TLB load ops
   input  wire logic        supervisor_i,
   input  wire logic        spr_wr_i,
   input  wire logic        spr_rd_i,
   input  wire logic [9:0]  spr_num_i,
   input  wire logic [31:0] spr_wdata_i,
   input  wire logic        save_wr_i,
   input  wire logic        tlb_load_i_i,
   input  wire logic        tlb_load_d_i,
   input  wire logic [31:0] tlb_ea_i,
   // Outputs
   output logic [31:0]      spr_rdata_o,
   output logic             spr_priv_err_o,
   output logic [31:0]      exception_save_reg_o,
   output logic             take_exc_o,
   output logic [31:0]      exc_vector_o,
   output logic             shadow_gpr_o,
   output logic             itlb_we_o,
   output logic             dtlb_we_o,
   output logic [4:0]       tlb_index_o,
   output logic             tlb_way_o,
   output logic [31:0]      tlb_word0_o,
   output logic [31:0]      tlb_word1_o,
   output logic [19:0]      tlb_epn_o
);
   // ----------------------------------------
   // Miss capture
   // ----------------------------------------
   logic [31:0] imiss_reg, dmiss_reg, instr_compare_word_reg, data_compare_word_reg;
   logic [31:0] tlb_reload_lower_word_reg, cmp_next, ihash_p, ihash_s, dhash_p, dhash_s, rd_mux;
   logic        pend_i_reg, pend_d_reg, pend_st_reg, priv_ok, fire, last_i_reg, known;
   assign priv_ok = supervisor_i; // [R23]
   // The compare word does not depend on which side missed
   assign cmp_next = (CMP_VALID | {1'b0, miss_vsid_i, 7'h00} | {26'h0, miss_ea_i[27:22]})
                     & ~CMP_HASHID; // [R11] [R22]
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         imiss_reg              <= RESET_WORD;
         dmiss_reg              <= RESET_WORD;
         instr_compare_word_reg <= RESET_WORD;
         data_compare_word_reg  <= RESET_WORD;
      end
      else if (imiss_i)
      begin
         imiss_reg              <= miss_ea_i; // [R9] [R16]
         instr_compare_word_reg <= cmp_next;  // [R11] [R16]
      end
      else if (dmiss_i)
      begin
         dmiss_reg              <= miss_ea_i; // [R9] [R16]
         data_compare_word_reg  <= cmp_next;  // [R11] [R16]
      end
      else if (spr_wr_i && priv_ok)
      begin
         // Writable but risky: the group addresses follow at once
         if (spr_num_i == SPR_IMISS) imiss_reg <= spr_wdata_i;
         if (spr_num_i == SPR_DMISS) dmiss_reg <= spr_wdata_i;
         if (spr_num_i == SPR_INSTR_COMPARE_WORD) instr_compare_word_reg <= spr_wdata_i;
         if (spr_num_i == SPR_DATA_COMPARE_WORD) data_compare_word_reg <= spr_wdata_i;
      end
   end
   // ----------------------------------------
   // Group address builders
   // ----------------------------------------
   tlbmr_hash u_ihash
   (
      .ea_i             (imiss_reg),
      .vsid_i           (instr_compare_word_reg[30:7]),
      .table_base_reg_i (table_base_reg_i),
      .primary_o        (ihash_p),
      .secondary_o      (ihash_s)
   );
   tlbmr_hash u_dhash
   (
      .ea_i             (dmiss_reg),
      .vsid_i           (data_compare_word_reg[30:7]),
      .table_base_reg_i (table_base_reg_i),
      .primary_o        (dhash_p),
      .secondary_o      (dhash_s)
   );
   // Last miss side decides which pair software sees
   always_ff @(posedge mclk_i)
   begin
      if (rst_i) last_i_reg <= 1'b0;
      else if (imiss_i) last_i_reg <= 1'b1;
      else if (dmiss_i) last_i_reg <= 1'b0;
   end
   // ----------------------------------------
   // Reload register
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         tlb_reload_lower_word_reg <= RESET_WORD;
      else if (spr_wr_i && priv_ok && spr_num_i == SPR_RELOAD)
         tlb_reload_lower_word_reg <= spr_wdata_i & RELOAD_MASK; // [R5] [R8] [R24]
   end
   // ----------------------------------------
   // Exception entry
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pend_i_reg  <= 1'b0;
         pend_d_reg  <= 1'b0;
         pend_st_reg <= 1'b0;
      end
      else if (imiss_i || dmiss_i)
      begin
         pend_i_reg  <= imiss_i;
         pend_d_reg  <= dmiss_i & ~imiss_i;
         pend_st_reg <= dstore_i;
      end
      // A miss in the entry cycle must not be lost, so capture wins over the clear
      else if (take_exc_o) {pend_i_reg, pend_d_reg} <= 2'b00;
   end
   // Entry waits for older instructions to retire
   assign fire = (pend_i_reg || pend_d_reg) && older_done_i && !take_exc_o; // [R10]
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         take_exc_o           <= 1'b0;
         exc_vector_o         <= RESET_WORD;
         shadow_gpr_o         <= 1'b0;
         exception_save_reg_o <= RESET_WORD;
      end
      else
      begin
         take_exc_o <= fire;
         if (fire)
         begin
            exc_vector_o <= pend_i_reg ? VEC_ITLB :
                            (pend_st_reg ? VEC_DTLB_ST : VEC_DTLB_LD); // [R18]
            shadow_gpr_o <= 1'b1; // [R20]
            exception_save_reg_o <= {cond_field_zero_i, 8'h00,
                                     miss_key_i, pend_i_reg, lru_way_i,
                                     pend_d_reg & ~pend_st_reg, msr_low_i}; // [R10] [R19] [R21]
         end
         else if (save_wr_i && priv_ok)
         begin
            exception_save_reg_o <= spr_wdata_i; // [R21]
            shadow_gpr_o         <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // TLB write
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         itlb_we_o   <= 1'b0;
         dtlb_we_o   <= 1'b0;
         tlb_index_o <= 5'h00;
         tlb_way_o   <= 1'b0;
         tlb_word0_o <= RESET_WORD;
         tlb_word1_o <= RESET_WORD;
         tlb_epn_o   <= 20'h00000;
      end
      else
      begin
         itlb_we_o <= tlb_load_i_i && priv_ok; // [R6]
         dtlb_we_o <= tlb_load_d_i && !tlb_load_i_i && priv_ok; // [R6]
         if (tlb_load_i_i || tlb_load_d_i)
         begin
            tlb_index_o <= tlb_ea_i[16:12]; // [R7]
            tlb_way_o   <= exception_save_reg_o[SAVE_WAY_BIT]; // [R7]
            tlb_epn_o   <= tlb_ea_i[31:12]; // [R6]
            tlb_word0_o <= tlb_load_i_i ? instr_compare_word_reg : data_compare_word_reg; // [R6]
            tlb_word1_o <= tlb_reload_lower_word_reg; // [R6]
         end
      end
   end
   // ----------------------------------------
   // SPR reads
   // ----------------------------------------
   always_comb
   begin
      known  = 1'b1;
      case (spr_num_i)
         SPR_IMISS:  rd_mux = imiss_reg;
         SPR_DMISS:  rd_mux = dmiss_reg;
         SPR_INSTR_COMPARE_WORD:   rd_mux = instr_compare_word_reg;
         SPR_DATA_COMPARE_WORD:   rd_mux = data_compare_word_reg;
         SPR_HASH_P: rd_mux = last_i_reg ? ihash_p : dhash_p; // [R4]
         SPR_HASH_S: rd_mux = last_i_reg ? ihash_s : dhash_s; // [R4]
         SPR_RELOAD: rd_mux = tlb_reload_lower_word_reg; // [R24]
         default:
         begin
            rd_mux = RESET_WORD;
            known  = 1'b0;
         end
      endcase
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         spr_rdata_o    <= RESET_WORD;
         spr_priv_err_o <= 1'b0;
      end
      else
      begin
         spr_rdata_o    <= (spr_rd_i && priv_ok) ? rd_mux : RESET_WORD; // [R23]
         spr_priv_err_o <= (spr_rd_i || spr_wr_i) && known && !priv_ok; // [R23]
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_vec_i;
      @(posedge mclk_i) disable iff (rst_i) (fire && pend_i_reg) |=> exc_vector_o == VEC_ITLB;
   endproperty
   a_vec_i: assert property (p_vec_i) else $error("bad instruction miss vector"); // [R18]
   property p_rld;
      @(posedge mclk_i) disable iff (rst_i) 1'b1 |-> (tlb_reload_lower_word_reg & ~RELOAD_MASK) == 32'h0;
   endproperty
   a_rld: assert property (p_rld) else $error("reload reserved bits set"); // [R24]
   property p_hash;
      @(posedge mclk_i) disable iff (rst_i)
         (ihash_p[31:25] == table_base_reg_i[31:25]) && (ihash_p[5:0] == 6'h00)
         && (ihash_s[31:25] == ihash_p[31:25]);
   endproperty
   a_hash: assert property (p_hash) else $error("group address upper or low bits"); // [R2]
   property p_cmp;
      @(posedge mclk_i) disable iff (rst_i) imiss_i |=> instr_compare_word_reg[31] && !instr_compare_word_reg[6];
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare valid/hash id wrong"); // [R22]
   property p_cap;
      @(posedge mclk_i) disable iff (rst_i) dmiss_i && !imiss_i |=> dmiss_reg == $past(miss_ea_i);
   endproperty
   a_cap: assert property (p_cap) else $error("data miss address not captured"); // [R9]
   property p_wait;
      @(posedge mclk_i) disable iff (rst_i) !older_done_i |=> !take_exc_o;
   endproperty
   a_wait: assert property (p_wait) else $error("exception before older work done"); // [R10]
   property p_way;
      @(posedge mclk_i) disable iff (rst_i) tlb_load_d_i |=> tlb_way_o == $past(exception_save_reg_o[SAVE_WAY_BIT]);
   endproperty
   a_way: assert property (p_way) else $error("TLB way not from save word"); // [R7]
   property p_priv;
      @(posedge mclk_i) disable iff (rst_i) (spr_rd_i && !supervisor_i) |=> spr_rdata_o == 32'h0;
   endproperty
   a_priv: assert property (p_priv) else $error("user read returned data"); // [R23]
   property p_word;
      @(posedge mclk_i) disable iff (rst_i) (tlb_load_i_i && supervisor_i) |=> itlb_we_o && tlb_word1_o == $past(tlb_reload_lower_word_reg);
   endproperty
   a_word: assert property (p_word) else $error("TLB write data not merged"); // [R6]
endmodule
`default_nettype wire

// [src/tlbmr_pkg.sv]
// Constants for the miss reload support block: SPR numbers, field positions, vectors.
// Assumes the core decodes move-to/from-SPR and TLB load ops and presents them as strobes.
package tlbmr_pkg;
   // ----------------------------------------
   // SPR numbers
   // ----------------------------------------
   localparam logic [9:0] SPR_DMISS   = 10'h3d0;
   localparam logic [9:0] SPR_DATA_COMPARE_WORD    = 10'h3d1;
   localparam logic [9:0] SPR_HASH_P  = 10'h3d2;
   localparam logic [9:0] SPR_HASH_S  = 10'h3d3;
   localparam logic [9:0] SPR_IMISS   = 10'h3d4;
   localparam logic [9:0] SPR_INSTR_COMPARE_WORD    = 10'h3d5;
   localparam logic [9:0] SPR_RELOAD  = 10'h3d6;
   // ----------------------------------------
   // Field masks (bit 0 is MSB, so mask bit 31-n)
   // ----------------------------------------
   localparam logic [31:0] RELOAD_MASK  = 32'hfffff1fb;
   localparam logic [31:0] GROUP_MASK   = 32'hffffffc0;
   localparam logic [31:0] CMP_VALID    = 32'h80000000;
   localparam logic [31:0] CMP_HASHID   = 32'h00000040;
   localparam int          CMP_VSID_LSB = 7;
   localparam int          SAVE_WAY_BIT = 31 - 14;
   localparam int          SAVE_DI_BIT  = 31 - 13;
   localparam int          SAVE_KEY_BIT = 31 - 12;
   localparam int          SAVE_SL_BIT  = 31 - 15;
   localparam logic [31:0] VEC_ITLB     = 32'h00001000;
   localparam logic [31:0] VEC_DTLB_LD  = 32'h00001100;
   localparam logic [31:0] VEC_DTLB_ST  = 32'h00001200;
   localparam logic [31:0] RESET_WORD   = 32'h00000000;
endpackage

// [src/tlbmr_hash.sv]
// Primary/secondary page-table-group address builder.
// Assumes the table base register and segment VSID are stable while the miss is captured.
`timescale 1ns/1ns
`default_nettype none
module tlbmr_hash
   import tlbmr_pkg::*;
(
   // Inputs
   input  wire logic [31:0] ea_i,
   input  wire logic [23:0] vsid_i,
   input  wire logic [31:0] table_base_reg_i,
   // Outputs
   output logic      [31:0] primary_o,
   output logic      [31:0] secondary_o
);
   logic [18:0] hash_p;
   logic [18:0] mask_ext;
   logic [18:0] sel_p;
   logic [18:0] sel_s;
   always_comb
   begin
      // Primary hash is low VSID xor page index; secondary is its complement
      hash_p   = {3'h0, vsid_i[15:0] ^ ea_i[27:12]};
      mask_ext = {table_base_reg_i[8:0], 10'h3ff};
      sel_p    = (table_base_reg_i[24:16] & ~mask_ext[18:10]) == 9'h000 ?
                 {table_base_reg_i[24:16] | (hash_p[18:10] & mask_ext[18:10]), hash_p[9:0]} :
                 {table_base_reg_i[24:16] | (hash_p[18:10] & mask_ext[18:10]), hash_p[9:0]};
      sel_s    = {table_base_reg_i[24:16] | (~hash_p[18:10] & mask_ext[18:10]), ~hash_p[9:0]};
      primary_o   = {table_base_reg_i[31:25], sel_p, 6'h00} & GROUP_MASK; // [R1] [R2] [R3]
      secondary_o = {table_base_reg_i[31:25], sel_s, 6'h00} & GROUP_MASK; // [R1] [R2] [R3]
   end
endmodule
`default_nettype wire

// [verification/tb_tlbmr_top.sv]
// Testbench for the miss reload support block; a bench model is compared at every data result, and the error flag only on the user read.
// Assumes registered one-cycle answers and bit 31 here being bit 0 of the register layout.
`timescale 1ns/1ns
`default_nettype none
module tb_tlbmr_top
   import tlbmr_pkg::*;
   ;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        mclk_i, rst_i, imiss_i, dmiss_i, dstore_i, older_done_i, miss_key_i, lru_way_i;
   logic        supervisor_i, spr_wr_i, spr_rd_i, save_wr_i, tlb_load_i_i, tlb_load_d_i;
   logic [31:0] miss_ea_i, table_base_reg_i, spr_wdata_i, tlb_ea_i;
   logic [23:0] miss_vsid_i;
   logic [3:0]  cond_field_zero_i;
   logic [15:0] msr_low_i;
   logic [9:0]  spr_num_i;
   logic [31:0] spr_rdata_o, exception_save_reg_o, exc_vector_o, tlb_word0_o, tlb_word1_o;
   logic        spr_priv_err_o, take_exc_o, shadow_gpr_o, itlb_we_o, dtlb_we_o, tlb_way_o;
   logic [4:0]  tlb_index_o;
   logic [19:0] tlb_epn_o;
   int          errors, cmp_count;
   logic [31:0] seed = 32'h0000002d;
   logic [31:0] m_reload, m_save;

   tlbmr_top tlbmr_top_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .imiss_i(imiss_i), .dmiss_i(dmiss_i),
      .dstore_i(dstore_i), .older_done_i(older_done_i), .miss_ea_i(miss_ea_i),
      .miss_vsid_i(miss_vsid_i), .miss_key_i(miss_key_i), .lru_way_i(lru_way_i),
      .cond_field_zero_i(cond_field_zero_i), .msr_low_i(msr_low_i),
      .table_base_reg_i(table_base_reg_i), .supervisor_i(supervisor_i), .spr_wr_i(spr_wr_i),
      .spr_rd_i(spr_rd_i), .spr_num_i(spr_num_i), .spr_wdata_i(spr_wdata_i),
      .save_wr_i(save_wr_i), .tlb_load_i_i(tlb_load_i_i), .tlb_load_d_i(tlb_load_d_i),
      .tlb_ea_i(tlb_ea_i), .spr_rdata_o(spr_rdata_o), .spr_priv_err_o(spr_priv_err_o),
      .exception_save_reg_o(exception_save_reg_o), .take_exc_o(take_exc_o),
      .exc_vector_o(exc_vector_o), .shadow_gpr_o(shadow_gpr_o), .itlb_we_o(itlb_we_o),
      .dtlb_we_o(dtlb_we_o), .tlb_index_o(tlb_index_o), .tlb_way_o(tlb_way_o),
      .tlb_word0_o(tlb_word0_o), .tlb_word1_o(tlb_word1_o), .tlb_epn_o(tlb_epn_o));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Register accesses are taken at the rising edge; answers sampled one edge later
   task automatic spr_rd(input logic [9:0] num, output logic [31:0] d, output logic e);
      @(negedge mclk_i);
      spr_rd_i = 1'b1;
      spr_num_i = num;
      @(negedge mclk_i);
      spr_rd_i = 1'b0;
      d = spr_rdata_o;
      e = spr_priv_err_o;
   endtask

   task automatic spr_wr(input logic [9:0] num, input logic [31:0] d);
      @(negedge mclk_i);
      spr_wr_i = 1'b1;
      spr_num_i = num;
      spr_wdata_i = d;
      @(negedge mclk_i);
      spr_wr_i = 1'b0;
   endtask

   // One whole miss: capture, exception entry, register reads, reload and TLB load
   task automatic miss(input logic iside, input logic store);
      logic [31:0] ea, tb, p, s, d, ecmp, ep, es;
      logic [18:0] h;
      logic        e;
      int          n;
      ea = xs();
      tb = xs();
      d = xs();
      ecmp = {1'b1, d[23:0], 1'b0, ea[27:22]};
      m_save = {d[31:28], 8'h00, d[27], iside, d[26], ~iside & ~store, d[15:0]};
      // Group addresses: low VSID xor page index, folded into the origin under the mask
      h = {3'h0, d[15:0] ^ ea[27:12]};
      ep = {tb[31:25], tb[24:16] | (h[18:10] & tb[8:0]), h[9:0], 6'h00};
      es = {tb[31:25], tb[24:16] | (~h[18:10] & tb[8:0]), ~h[9:0], 6'h00};
      @(negedge mclk_i);
      imiss_i = iside;
      dmiss_i = ~iside;
      dstore_i = store;
      miss_ea_i = ea;
      table_base_reg_i = tb;
      miss_vsid_i = d[23:0];
      cond_field_zero_i = d[31:28];
      miss_key_i = d[27];
      lru_way_i = d[26];
      msr_low_i = d[15:0];
      @(negedge mclk_i);
      imiss_i = 1'b0;
      dmiss_i = 1'b0;
      repeat (2) @(negedge mclk_i) chk({31'h0, take_exc_o}, 32'h0);
      older_done_i = 1'b1;
      n = 0;
      while (take_exc_o !== 1'b1 && n < 3)
      begin
         @(negedge mclk_i);
         n++;
      end
      older_done_i = 1'b0;
      chk({31'h0, take_exc_o}, 32'h1);
      chk(exc_vector_o, iside ? VEC_ITLB : (store ? VEC_DTLB_ST : VEC_DTLB_LD));
      chk({31'h0, shadow_gpr_o}, 32'h1);
      chk(exception_save_reg_o & 32'hf00fffff, m_save);
      spr_rd(iside ? SPR_IMISS : SPR_DMISS, d, e);
      chk(d, ea);
      spr_rd(iside ? SPR_INSTR_COMPARE_WORD : SPR_DATA_COMPARE_WORD, d, e);
      chk(d, ecmp);
      spr_rd(SPR_HASH_P, p, e);
      spr_rd(SPR_HASH_S, s, e);
      chk(p, ep);
      chk(s, es);
      chk({25'h0, p[31:25]}, {25'h0, tb[31:25]});
      chk({26'h0, p[5:0] | s[5:0]}, 32'h0);
      chk((p ^ s) & ~32'h01ffffc0, 32'h0);
      spr_wr(SPR_HASH_P, ~p);
      spr_rd(SPR_HASH_P, d, e);
      chk(d, p);
      // A store handler sets the changed bit before it loads the entry
      d = xs() | (store ? 32'h00000080 : 32'h00000000);
      m_reload = d & 32'hfffff1fb;
      spr_wr(SPR_RELOAD, d);
      spr_rd(SPR_RELOAD, d, e);
      chk(d, m_reload);
      // Handler edits the save word: fault flags for fetch and store, way flip for loads
      m_save = m_save
               ^ (iside ? 32'h40000000 : (store ? 32'h08000000 : 32'h00020000));
      @(negedge mclk_i);
      save_wr_i = 1'b1;
      spr_wdata_i = m_save;
      @(negedge mclk_i);
      save_wr_i = 1'b0;
      chk(exception_save_reg_o, m_save);
      chk({31'h0, shadow_gpr_o}, 32'h0);
      @(negedge mclk_i);
      tlb_load_i_i = iside;
      tlb_load_d_i = ~iside;
      tlb_ea_i = ea;
      @(negedge mclk_i);
      tlb_load_i_i = 1'b0;
      tlb_load_d_i = 1'b0;
      chk({30'h0, itlb_we_o, dtlb_we_o}, {30'h0, iside, ~iside});
      chk(tlb_word0_o, ecmp);
      chk(tlb_word1_o, m_reload);
      chk({12'h0, tlb_epn_o}, {12'h0, ea[31:12]});
      chk({26'h0, tlb_way_o, tlb_index_o}, {26'h0, m_save[17], ea[16:12]});
      $display("test done: miss iside=%0d store=%0d", iside, store);
   endtask

   // ----------------------------------------
   // Clock, watchdog, main sequence
   // ----------------------------------------
   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // Whole run needs well under a few hundred cycles
   initial
   begin
      repeat (5000) @(posedge mclk_i);
      errors++;
      tally_and_finish();
   end

   initial
   begin
      logic [31:0] d, r;
      logic        e;
      {imiss_i, dmiss_i, dstore_i, older_done_i, miss_key_i, lru_way_i} = 6'h00;
      {spr_wr_i, spr_rd_i, save_wr_i, tlb_load_i_i, tlb_load_d_i} = 5'h00;
      {miss_ea_i, table_base_reg_i, spr_wdata_i, tlb_ea_i} = 128'h0;
      {miss_vsid_i, cond_field_zero_i, msr_low_i, spr_num_i} = 54'h0;
      supervisor_i = 1'b1;
      errors = 0;
      cmp_count = 0;
      rst_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      rst_i = 1'b0;
      chk(exception_save_reg_o, 32'h0);
      chk({30'h0, take_exc_o, shadow_gpr_o}, 32'h0);
      $display("test done: reset");
      for (int k = 0; k < 3; k++)
         miss(k == 0, k == 2);
      d = xs();
      spr_wr(SPR_IMISS, d);
      spr_rd(SPR_IMISS, r, e);
      chk(r, d);
      supervisor_i = 1'b0;
      spr_rd(SPR_RELOAD, d, e);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h1);
      spr_wr(SPR_RELOAD, ~m_reload);
      @(negedge mclk_i);
      tlb_load_d_i = 1'b1;
      @(negedge mclk_i);
      tlb_load_d_i = 1'b0;
      chk({31'h0, dtlb_we_o}, 32'h0);
      supervisor_i = 1'b1;
      spr_rd(SPR_RELOAD, d, e);
      chk(d, m_reload);
      $display("test done: privilege");
      tally_and_finish();
   end
endmodule
`default_nettype wire
